// [hw/ssrd_top.sv]
// Our own choices: the plain strobed port and the placing of the registers.
`include "ssrd_map.svh"

// Contract
// - previous select echoed in status bits 12:8
// - selection held until next valid select
// - diag code returns selected output's config
// - protection code returns supply protect config
// - watchdog code returns watchdog config
// - bit two high when watchdog expired
// - expired bit low in normal mode
// - strap code returns output two/zero states
// - strap bit one shows watchdog enable
// - strap bit zero shows wake level
// - direct code returns four input levels
// - extended code returns latch config three/two
// - unconfigured device uses defaults, protections on
// - inputs drive outputs, fault pin asserts
// - reset defaults: protections on, first levels
// - eight low, two high trip levels
// - four watchdog timings, first by default
// - sense ratios only by serial config
// - temperature latching default, serially changeable
module ssrd_top #(
  parameter int WD_T0_MS  = 10,
  parameter int WD_T1_MS  = 30,
  parameter int WD_T2_MS  = 100,
  parameter int WD_T3_MS  = 300,
  parameter int WD_T0_CYC = WD_T0_MS * (`SSRD_CLK_HZ / 1000),
  parameter int WD_T1_CYC = WD_T1_MS * (`SSRD_CLK_HZ / 1000),
  parameter int WD_T2_CYC = WD_T2_MS * (`SSRD_CLK_HZ / 1000),
  parameter int WD_T3_CYC = WD_T3_MS * (`SSRD_CLK_HZ / 1000)
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [7:0]        bus_addr,
  input  wire logic [31:0]       bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic      [31:0]       bus_rdata,
  input  wire logic              link_cs_n,
  input  wire logic              link_sclk,
  input  wire logic              link_si,
  output logic                   link_so,
  output logic                   link_so_oe,
  input  wire logic              wake_pin,
  input  wire logic              failsafe_strap_input,
  input  wire logic              fs_strap_hs2,
  input  wire logic              fs_strap_hs0,
  input  wire logic [3:0]        direct_control_inputs,
  output ssrd_pkg::ssrd_nib_t    switch_out,
  output logic                   fault_flag_n
);
  import ssrd_pkg::*;

  // pin synchronisers
  logic [10:0] pins_s;
  ssrd_sync #(.W(11)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .d_in    ({direct_control_inputs, fs_strap_hs0, fs_strap_hs2,
                failsafe_strap_input, wake_pin, link_si, link_sclk, link_cs_n}),
    .q_out   (pins_s)
  );

  wire       cs_n_s  = pins_s[0];
  wire       sclk_s  = pins_s[1];
  wire       si_s    = pins_s[2];
  wire       wake_s  = pins_s[3];
  wire       fsi_s   = pins_s[4];
  wire       hs2_s   = pins_s[5];
  wire       hs0_s   = pins_s[6];
  wire [3:0] din_s   = pins_s[10:7];

  // state
  ssrd_link_t link_ff;
  ssrd_link_t nxt_link;
  logic       sclk_q_ff;
  logic       cs_q_ff;
  logic [4:0] bit_cnt_ff;
  ssrd_word_t rx_ff;
  ssrd_word_t tx_ff;
  logic       wd_in_ff;
  ssrd_sel_t  prev_read_select_ff;
  ssrd_nib_t  in_spi_ff;
  ssrd_nib_t  sense_dis_n_ff;
  ssrd_nib_t  ocl_cfg_ff [4];
  ssrd_nib_t  blank_cfg_ff [4];
  ssrd_nib_t  diag_slew_config_ff [4];
  ssrd_nib_t  supply_protect_config_ff;
  ssrd_nib_t  watchdog_config_ff;
  logic       strap_done_ff;
  logic [1:0] strap_age_ff;
  logic       wd_en_ff;
  logic       fs_hs2_ff;
  logic       fs_hs0_ff;
  logic [31:0] wd_cnt_ff;
  logic       watchdog_expired_flag_ff;
  logic [5:0] fault_ff;
  ssrd_nib_t  switch_out_ff;
  logic       fault_flag_n_ff;
  logic [31:0] bus_rdata_ff;

  // link edge and frame decode
  wire sclk_rise  = sclk_s & ~sclk_q_ff;
  wire sclk_fall  = ~sclk_s & sclk_q_ff;
  wire cs_fall    = ~cs_n_s & cs_q_ff;
  wire cs_rise    = cs_n_s & ~cs_q_ff;
  wire frame_ok   = cs_rise && (link_ff == LK_SHIFT) && (bit_cnt_ff == `SSRD_FRAME_BITS);
  wire [1:0] f_osel = rx_ff[`SSRD_OSEL_HI:`SSRD_OSEL_LO];
  wire [2:0] f_code = rx_ff[`SSRD_CODE_HI:`SSRD_CODE_LO];
  wire [3:0] f_data = rx_ff[`SSRD_DATA_HI:0];
  wire wr_stat   = frame_ok && f_code == `SSRD_CODE_STAT;
  wire wr_ocr0   = frame_ok && f_code == `SSRD_CODE_OCR && f_osel == `SSRD_OSEL_ZERO;
  wire wr_ocr1   = frame_ok && f_code == `SSRD_CODE_OCR && f_osel == `SSRD_OSEL_ONE;
  wire wr_ocl    = frame_ok && f_code == `SSRD_CODE_OCL;
  wire wr_blank  = frame_ok && f_code == `SSRD_CODE_BLANK;
  wire wr_diag   = frame_ok && f_code == `SSRD_CODE_DIAG;
  wire wr_prot   = frame_ok && f_code == `SSRD_CODE_PROT && f_osel == `SSRD_OSEL_ZERO;
  wire wr_wdr    = frame_ok && f_code == `SSRD_CODE_PROT && f_osel == `SSRD_OSEL_ONE;

  // readback selection
  wire [2:0] s_code = prev_read_select_ff[2:0];
  wire [1:0] s_osel = prev_read_select_ff[4:3];
  wire       s_a0   = prev_read_select_ff[`SSRD_A0_BIT];
  wire       s_hi   = prev_read_select_ff[4];
  wire [3:0] nib_ocr  = s_a0 ? sense_dis_n_ff : in_spi_ff;
  wire [3:0] nib_wdr  = {1'b0, watchdog_expired_flag_ff, watchdog_config_ff[1:0]};
  wire [3:0] nib_prot = s_a0 ? nib_wdr : supply_protect_config_ff;
  wire [3:0] nib_pin0 = {fs_hs2_ff, fs_hs0_ff, wd_en_ff, wake_s};
  wire [3:0] nib_pin  = s_a0 ? din_s : nib_pin0;
  wire [3:0] nib_pinx = {watchdog_config_ff[3:2], 2'b00};
  wire [3:0] so_nib =
      (s_code == `SSRD_CODE_OCR   && !s_hi) ? nib_ocr :
      (s_code == `SSRD_CODE_OCL)            ? ocl_cfg_ff[s_osel] :
      (s_code == `SSRD_CODE_BLANK)          ? blank_cfg_ff[s_osel] :
      (s_code == `SSRD_CODE_DIAG)           ? diag_slew_config_ff[s_osel] :
      (s_code == `SSRD_CODE_PROT  && !s_hi) ? nib_prot :
      (s_code == `SSRD_CODE_PIN   && !s_hi) ? nib_pin :
      (s_code == `SSRD_CODE_PINX  && s_osel == `SSRD_OSEL_ONE) ? nib_pinx :
      `SSRD_RST_NIB;
  wire [3:0] fault_out = fault_ff[3:0];
  wire [15:0] so_word = {wd_in_ff, fault_ff[`SSRD_FLT_UV], fault_ff[`SSRD_FLT_OV],
                         prev_read_select_ff, fault_out, so_nib};

  // watchdog
  wire [31:0] wd_period =
      (watchdog_config_ff[1:0] == 2'h0) ? 32'(WD_T0_CYC) :
      (watchdog_config_ff[1:0] == 2'h1) ? 32'(WD_T1_CYC) :
      (watchdog_config_ff[1:0] == 2'h2) ? 32'(WD_T2_CYC) : 32'(WD_T3_CYC);
  wire        wd_hit = wd_en_ff && (wd_cnt_ff >= wd_period - 32'h1);
  wire        nxt_expired = wake_s && (watchdog_expired_flag_ff || wd_hit);
  wire        strap_take = strap_age_ff == `SSRD_STRAP_AGE;
  wire [31:0] nxt_wd_cnt = (frame_ok || !wd_en_ff || watchdog_expired_flag_ff) ?
                           `SSRD_RST_WD : wd_cnt_ff + 32'h1;

  // output control and protection
  wire uv_off = fault_ff[`SSRD_FLT_UV] & ~supply_protect_config_ff[`SSRD_PROT_UVDIS];
  wire ov_off = fault_ff[`SSRD_FLT_OV] & ~supply_protect_config_ff[`SSRD_PROT_OVDIS];
  wire [3:0] fs_state = {1'b0, fs_hs2_ff, 1'b0, fs_hs0_ff};
  ssrd_nib_t nxt_switch;
  for (genvar i = 0; i < 4; i++) begin : g_out
    wire use_din = din_s[i] & ~diag_slew_config_ff[i][`SSRD_DIAG_DIRDIS];
    wire ctl_on  = diag_slew_config_ff[i][`SSRD_DIAG_AO] ? (use_din & in_spi_ff[i]) :
                                                          (use_din | in_spi_ff[i]);
    assign nxt_switch[i] = ~fault_out[i] & ~uv_off & ~ov_off &
                           (watchdog_expired_flag_ff ? fs_state[i] : ctl_on);
  end
  wire nxt_fault_n = ~(|fault_out | fault_ff[`SSRD_FLT_UV] | fault_ff[`SSRD_FLT_OV]);

  // register bus decode
  wire hit_status = bus_addr == `SSRD_OFF_STATUS;
  wire hit_fault  = bus_addr == `SSRD_OFF_FAULT;
  wire [31:0] rd_status = {24'h000000, prev_read_select_ff, wd_en_ff,
                           watchdog_expired_flag_ff, 1'b0};
  wire [31:0] rd_fault  = {26'h0000000, fault_ff};
  wire [31:0] nxt_rdata = !bus_rd    ? `SSRD_RST_DATA :
                          hit_status ? rd_status :
                          hit_fault  ? rd_fault : `SSRD_RST_DATA;

  // link sequencing
  always_comb begin
    nxt_link = link_ff;
    unique case (link_ff)
      LK_IDLE:  if (cs_fall) nxt_link = LK_SHIFT;
      LK_SHIFT: if (cs_rise) nxt_link = LK_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link_ff    <= LK_IDLE;
      sclk_q_ff  <= 1'b0;
      cs_q_ff    <= 1'b1;
      bit_cnt_ff <= `SSRD_RST_CNT;
      rx_ff      <= `SSRD_RST_WORD;
      tx_ff      <= `SSRD_RST_WORD;
    end else if (ce) begin
      link_ff   <= nxt_link;
      sclk_q_ff <= sclk_s;
      cs_q_ff   <= cs_n_s;
      if (cs_fall) begin
        bit_cnt_ff <= `SSRD_RST_CNT;
        tx_ff      <= so_word;
      end else if (link_ff == LK_SHIFT && sclk_rise) begin
        rx_ff      <= {rx_ff[14:0], si_s};
        bit_cnt_ff <= bit_cnt_ff + `SSRD_CNT_ONE;
      end else if (link_ff == LK_SHIFT && sclk_fall) begin
        tx_ff <= {tx_ff[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link_so    <= 1'b0;
      link_so_oe <= 1'b0;
    end else if (ce) begin
      link_so    <= tx_ff[`SSRD_SO_MSB];
      link_so_oe <= (link_ff == LK_SHIFT) & ~cs_n_s;
    end
  end

  // serial configuration; defaults apply until written
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wd_in_ff                 <= 1'b0;
      prev_read_select_ff      <= `SSRD_RST_SEL;
      in_spi_ff                <= `SSRD_RST_NIB;
      sense_dis_n_ff           <= `SSRD_RST_SENSE_N;
      supply_protect_config_ff <= `SSRD_RST_NIB;
      watchdog_config_ff       <= `SSRD_RST_NIB;
    end else if (ce && frame_ok) begin
      wd_in_ff <= rx_ff[`SSRD_WD_BIT];
      if (wr_stat) prev_read_select_ff <= rx_ff[`SSRD_SDATA_HI:0];
      if (wr_ocr0) in_spi_ff <= f_data;
      if (wr_ocr1) sense_dis_n_ff <= f_data;
      if (wr_prot) supply_protect_config_ff <= f_data;
      if (wr_wdr) watchdog_config_ff <= f_data;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_cfg
    wire sel_me = f_osel == 2'(i);
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        ocl_cfg_ff[i]          <= `SSRD_RST_NIB;
        blank_cfg_ff[i]        <= `SSRD_RST_NIB;
        diag_slew_config_ff[i] <= `SSRD_RST_NIB;
      end else if (ce && sel_me) begin
        if (wr_ocl) ocl_cfg_ff[i] <= f_data;
        if (wr_blank) blank_cfg_ff[i] <= f_data;
        if (wr_diag) diag_slew_config_ff[i] <= f_data;
      end
    end
  end

  // straps caught once, after the synchronisers hold real pin levels
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strap_age_ff  <= `SSRD_RST_AGE;
      strap_done_ff <= 1'b0;
      wd_en_ff      <= 1'b0;
      fs_hs2_ff     <= 1'b0;
      fs_hs0_ff     <= 1'b0;
    end else if (ce && !strap_done_ff) begin
      strap_age_ff <= strap_age_ff + `SSRD_AGE_ONE;
      if (strap_take) begin
        strap_done_ff <= 1'b1;
        wd_en_ff      <= fsi_s;
        fs_hs2_ff     <= hs2_s;
        fs_hs0_ff     <= hs0_s;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wd_cnt_ff                <= `SSRD_RST_WD;
      watchdog_expired_flag_ff <= 1'b0;
      fault_ff                 <= `SSRD_RST_FAULT;
      switch_out_ff            <= `SSRD_RST_NIB;
      fault_flag_n_ff          <= 1'b1;
      bus_rdata_ff             <= `SSRD_RST_DATA;
    end else if (ce) begin
      wd_cnt_ff                <= nxt_wd_cnt;
      watchdog_expired_flag_ff <= nxt_expired;
      if (bus_wr && hit_fault) fault_ff <= bus_wdata[5:0];
      switch_out_ff            <= nxt_switch;
      fault_flag_n_ff          <= nxt_fault_n;
      bus_rdata_ff             <= nxt_rdata;
    end
  end

  assign switch_out   = switch_out_ff;
  assign fault_flag_n = fault_flag_n_ff;
  assign bus_rdata    = bus_rdata_ff;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_select_frame;
    ce && wr_stat;
  endsequence
  sequence s_load_word;
    ce && cs_fall;
  endsequence

  chk_select_echo: assert property (
    s_load_word |=> tx_ff[12:8] == $past(prev_read_select_ff))
    else $error("status select field wrong");
  chk_select_hold: assert property (
    ce && !wr_stat |=> $stable(prev_read_select_ff))
    else $error("selection changed without select frame");
  chk_select_take: assert property (
    s_select_frame |=> prev_read_select_ff == $past(rx_ff[4:0]))
    else $error("selection not taken");
  chk_wdr_nibble: assert property (
    s_load_word and prev_read_select_ff == 5'h0D |=>
    tx_ff[3] == 1'b0 && tx_ff[2] == $past(watchdog_expired_flag_ff))
    else $error("watchdog readback wrong");
  chk_expire_low: assert property (
    !wd_en_ff |-> ##1 !watchdog_expired_flag_ff || $past(watchdog_expired_flag_ff))
    else $error("expired without watchdog");
  chk_pin_nibble: assert property (
    s_load_word and prev_read_select_ff == 5'h06 |=>
    tx_ff[3:1] == $past({fs_hs2_ff, fs_hs0_ff, wd_en_ff}) && tx_ff[0] == $past(wake_s))
    else $error("strap readback wrong");
  chk_din_nibble: assert property (
    s_load_word and prev_read_select_ff == 5'h0E |=> tx_ff[3:0] == $past(din_s))
    else $error("direct input readback wrong");
  chk_zero_nibble: assert property (
    s_load_word and prev_read_select_ff == 5'h10 |=> tx_ff[3:0] == 4'h0)
    else $error("undefined readback not zero");
  chk_fault_pin: assert property (
    ce && |fault_ff |=> !fault_flag_n)
    else $error("fault pin not asserted");
  chk_strap_take: assert property (
    ce && strap_take |=> wd_en_ff == $past(fsi_s) && fs_hs2_ff == $past(hs2_s))
    else $error("strap not caught");
  chk_fault_off: assert property (
    ce && fault_ff[0] |=> !switch_out[0])
    else $error("faulted output still on");
endmodule

// [inc/ssrd_map.svh]
`ifndef SSRD_MAP_SVH
`define SSRD_MAP_SVH

`define SSRD_CLK_HZ        10000000
`define SSRD_FRAME_BITS    5'h10
`define SSRD_CNT_ONE       5'h01
`define SSRD_SO_MSB        15
`define SSRD_WD_BIT        15
`define SSRD_ADDR_HI       12
`define SSRD_ADDR_LO       8
`define SSRD_OSEL_HI       12
`define SSRD_OSEL_LO       11
`define SSRD_CODE_HI       10
`define SSRD_CODE_LO       8
`define SSRD_DATA_HI       3
`define SSRD_SDATA_HI      4

`define SSRD_CODE_STAT     3'h0
`define SSRD_CODE_OCR      3'h1
`define SSRD_CODE_OCL      3'h2
`define SSRD_CODE_BLANK    3'h3
`define SSRD_CODE_DIAG     3'h4
`define SSRD_CODE_PROT     3'h5
`define SSRD_CODE_PIN      3'h6
`define SSRD_CODE_PINX     3'h7
`define SSRD_OSEL_ZERO     2'h0
`define SSRD_OSEL_ONE      2'h1
`define SSRD_A0_BIT        3

`define SSRD_OFF_STATUS    8'h00
`define SSRD_OFF_FAULT     8'h04

`define SSRD_RST_SEL       5'h00
`define SSRD_RST_NIB       4'h0
`define SSRD_RST_SENSE_N   4'hF
`define SSRD_RST_FAULT     6'h00
`define SSRD_RST_WORD      16'h0000
`define SSRD_RST_CNT       5'h00
`define SSRD_RST_WD        32'h0000_0000
`define SSRD_RST_DATA      32'h0000_0000
`define SSRD_RST_AGE       2'h0
`define SSRD_AGE_ONE       2'h1
`define SSRD_STRAP_AGE     2'h2

`define SSRD_DIAG_AO       0
`define SSRD_DIAG_DIRDIS   1
`define SSRD_PROT_OVDIS    0
`define SSRD_PROT_UVDIS    1
`define SSRD_FLT_UV        4
`define SSRD_FLT_OV        5

`endif

// [inc/ssrd_pkg.sv]
package ssrd_pkg;
  typedef enum logic [0:0] {LK_IDLE, LK_SHIFT} ssrd_link_t;
  typedef logic [3:0] ssrd_nib_t;
  typedef logic [4:0] ssrd_sel_t;
  typedef logic [15:0] ssrd_word_t;
endpackage

// [hw/ssrd_sync.sv]
module ssrd_sync #(
  parameter int W = 11
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  import ssrd_pkg::*;

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // two flops per bit, first stage read only by the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        meta_ff[i] <= 1'b0;
        q_ff[i]    <= 1'b0;
      end else if (ce) begin
        meta_ff[i] <= d_in[i];
        q_ff[i]    <= meta_ff[i];
      end
    end
  end

  assign q_out = q_ff;
endmodule

// [bench/ssrd_host.sv]
module ssrd_host (
  output logic      link_cs_n,
  output logic      link_sclk,
  output logic      link_si,
  input  wire logic link_so,
  input  wire logic link_so_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic so_last = 1'b0;
  wire  so_seen = link_so_oe ? link_so : ~so_last;
  always @(link_so) if (link_so_oe) so_last = link_so;
  initial begin
    link_cs_n = 1'b1;
    link_sclk = 1'b0;
    link_si = 1'b0;
  end
  // n bits msb first; any n not equal to 16 modulo 32 makes a frame the device must drop
  task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
    r = '0;
    #23 link_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      link_si = w[15 - (i % 16)];
      #400 link_sclk = 1'b1;
      #390 r = {r[14:0], so_seen};
      #10 link_sclk = 1'b0;
    end
    #400 link_cs_n = 1'b1;
    link_si = ~link_si;
    #800;
  endtask
endmodule

// [bench/tb_ssrd_top.sv]
module tb_ssrd_top;
  import ssrd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T0 = 400;
  localparam int SL [10] = '{5'h10, 5'h04, 5'h0C, 5'h14, 5'h1C, 5'h05, 5'h0D, 5'h0F, 5'h06,
                             5'h0E};
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic        link_cs_n, link_sclk, link_si, link_so, link_so_oe;
  logic        wake_pin = 1'b1;
  logic        fs_in = 1'b0;
  logic [1:0]  strap_hs = 2'h0;
  logic [3:0]  dci = 4'h0;
  ssrd_nib_t   switch_out;
  logic        fault_flag_n;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          seed = 32'h0A06;
  int          diag [4];
  int          prot, wd, sel, wdb, watchdog_expired_flag;
  logic [31:0] d;

  ssrd_top #(.WD_T0_CYC(T0), .WD_T1_CYC(2 * T0), .WD_T2_CYC(3 * T0), .WD_T3_CYC(4 * T0))
  i_ssrd_top (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .link_cs_n(link_cs_n), .link_sclk(link_sclk), .link_si(link_si), .link_so(link_so),
    .link_so_oe(link_so_oe), .wake_pin(wake_pin), .failsafe_strap_input(fs_in),
    .fs_strap_hs2(strap_hs[1]), .fs_strap_hs0(strap_hs[0]), .direct_control_inputs(dci),
    .switch_out(switch_out), .fault_flag_n(fault_flag_n));
  ssrd_host i_ssrd_host (.link_cs_n(link_cs_n), .link_sclk(link_sclk), .link_si(link_si),
    .link_so(link_so), .link_so_oe(link_so_oe));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic bwr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic brd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask
  function automatic int nib(input int s);
    if (s % 8 == 4) return diag[s / 8];
    case (s)
      5'h05: return prot;
      5'h0D: return watchdog_expired_flag * 4 + (wd & 3);
      5'h0F: return wd & 12;
      5'h06: return strap_hs * 4 + fs_in * 2 + wake_pin;
      5'h0E: return dci;
      5'h10: return 0;
      default: return -1;
    endcase
  endfunction
  task automatic xf(input int a, input int c, input int v, input int n = 16);
    logic [15:0] w;
    logic [15:0] q;
    int e;
    w = 16'((a << 11) | (c << 8) | (v & 31));
    w[15] = 1'($random(seed));
    e = nib(sel);
    i_ssrd_host.frame(w, n, q);
    if (n == 16) begin
      chk("select", sel, 32'(q[12:8]));
      chk("wd bit", wdb, 32'(q[15]));
      if (e >= 0) chk("nibble", e, 32'(q[3:0]));
      wdb = w[15];
      if (c == 0) sel = v & 31;
      if (c == 4) diag[a] = v & 15;
      if (c == 5 && a == 0) prot = v & 15;
      if (c == 5 && a == 1) wd = v & 15;
    end
    @(posedge sys_clk);
    dci <= 4'($random(seed));
    @(posedge sys_clk);
  endtask
  task automatic do_reset(input logic wden);
    @(posedge sys_clk);
    rst <= 1'b1;
    fs_in <= wden;
    strap_hs <= 2'($random(seed));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    sel = 0;
    wdb = 0;
    watchdog_expired_flag = 0;
    prot = 0;
    wd = 0;
    foreach (diag[i]) diag[i] = 0;
  endtask

  initial begin
    do_reset(1'b0);
    for (int k = 0; k < 10; k++) xf(0, 0, SL[k]);
    xf(0, 0, 5'h00);
    $display("defaults done");
    brd(8'h00, d);
    chk("status", 32'(sel * 8), d);
    bwr(8'h08, 32'($random(seed)));
    brd(8'h08, d);
    chk("unmapped", 32'h0, d);
    @(posedge sys_clk);
    dci <= 4'($random(seed)) | 4'h1;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 20 && switch_out !== dci; i++) @(posedge sys_clk);
    chk("outputs", dci, switch_out);
    chk("fault pin idle", 32'h1, fault_flag_n);
    bwr(8'h04, 32'h1);
    brd(8'h04, d);
    chk("fault reg", 32'h1, d);
    for (int i = 0; i < 20 && fault_flag_n !== 1'b0; i++) @(posedge sys_clk);
    chk("fault pin", 32'h0, fault_flag_n);
    chk("output off", 32'h0, switch_out[0]);
    bwr(8'h04, 32'h0);
    $display("bus and standalone done");
    xf(0, 0, 5'h06);
    xf(0, 0, 5'h0E, 15);
    xf(0, 0, 5'h05, 17);
    xf(0, 0, 5'h0E);
    $display("bad frames done");
    repeat (2) begin
      for (int o = 0; o < 4; o++) xf(o, 4, $random(seed));
      xf(0, 5, $random(seed));
      xf(1, 5, $random(seed));
      for (int k = 0; k < 10; k++) xf(0, 0, SL[k]);
    end
    $display("config readback done");
    do_reset(1'b1);
    xf(0, 0, 5'h0D);
    xf(1, 5, 0);
    xf(0, 0, 5'h06);
    xf(0, 0, 5'h0D);
    repeat (T0 + 100) @(posedge sys_clk);
    watchdog_expired_flag = 1;
    xf(0, 0, 5'h0D);
    xf(0, 0, 5'h0D);
    brd(8'h00, d);
    chk("status expired", 32'(sel * 8 + 6), d);
    chk("failsafe outputs", 32'({1'b0, strap_hs[1], 1'b0, strap_hs[0]}), switch_out);
    @(posedge sys_clk);
    wake_pin <= 1'b0;
    repeat (10) @(posedge sys_clk);
    wake_pin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    watchdog_expired_flag = 0;
    xf(0, 0, 5'h0D);
    xf(0, 0, 5'h0D);
    $display("watchdog done");
    final_report();
  end
endmodule
